/* File: include/psm_pkg.sv */
package psm_pkg;

    // ------------------------------------------------------------
    // Power-save request codes carried by the instruction strobe.
    // ------------------------------------------------------------
    localparam logic [1:0] PSAVE_SLEEP = 2'h0;
    localparam logic [1:0] PSAVE_IDLE = 2'h1;

    // ------------------------------------------------------------
    // Deep-sleep control word layout and timing.
    // ------------------------------------------------------------
    localparam int DSCTL_EN_BIT = 15;
    localparam int CFG4_BOR_BIT = 6;
    localparam int ARM_WINDOW_CYC = 3;
    localparam int REARM_GAP_CYC = 3;
    localparam logic [15:0] DSCTL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Wake-source register bit positions.
    // ------------------------------------------------------------
    localparam int WK_POR = 0;
    localparam int WK_MASTER_CLEAR_RESET = 1;
    localparam int WK_RTC = 2;
    localparam int WK_INT0 = 3;
    localparam int WK_DEEP_SLEEP_WATCHDOG = 4;
    localparam int WK_DEEP_SLEEP_BROWNOUT_RESET = 5;
    localparam int WK_WIDTH = 6;

    // ------------------------------------------------------------
    // Controller register offsets (APB byte addresses).
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
    localparam logic [11:0] REG_WAKE = 12'h010;

    // Controller CTRL bit positions.
    localparam int CTL_WDT_EN = 0;
    localparam int CTL_FAIL_SAFE_CLOCK_MONITOR_EN = 1;
    localparam int CTL_REG_EN = 2;
    localparam int CTL_BOR_CFG = 3;
    localparam int CTL_INT0_EN = 4;
    localparam int CTL_RTC_EN = 5;

    // Interrupt event bit positions.
    localparam int EV_IDLE_WAKE = 0;
    localparam int EV_SLEEP_WAKE = 1;
    localparam int EV_DS_WAKE = 2;
    localparam int EV_ARM_LAPSE = 3;
    localparam int EV_WIDTH = 4;

    // Controller issue codes on the APB command register.
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_IDLE = 2'h1;
    localparam logic [1:0] CMD_SLEEP = 2'h2;
    localparam logic [1:0] CMD_DEEP = 2'h3;

endpackage

/* File: include/psm_if.sv */
`timescale 1ns/1ns
interface psm_if;
    logic psave_req;
    logic [1:0] psave_mode;
    logic dsctl_wr;
    logic [15:0] dsctl_wdata;
    logic [15:0] dsctl_rdata;
    logic release_clr;
    logic [5:0] wake_src;
    logic wake_clr;
    logic core_run;
    logic wake_vector;
    logic pending_irq;
    logic wdt_clr;
    logic low_power_rc_osc_on;
    logic sysclk_on;
    logic regulator_on;
    logic [15:0] ds_gpr0;
    logic [15:0] ds_gpr1;

    modport device (
        input psave_req, psave_mode, dsctl_wr, dsctl_wdata, release_clr, wake_clr,
        output dsctl_rdata, wake_src, core_run, wake_vector, pending_irq, wdt_clr,
        output low_power_rc_osc_on, sysclk_on, regulator_on, ds_gpr0, ds_gpr1
    );
    modport host (
        output psave_req, psave_mode, dsctl_wr, dsctl_wdata, release_clr, wake_clr,
        input dsctl_rdata, wake_src, core_run, wake_vector, pending_irq, wdt_clr,
        input low_power_rc_osc_on, sysclk_on, regulator_on, ds_gpr0, ds_gpr1
    );
endinterface

/* File: hdl/power_save_mode_control.sv */
`timescale 1ns/1ns
module power_save_mode_control (
    input wire logic pclk,
    input wire logic presetn,
    psm_if.device link,
    input wire logic irq_any,
    input wire logic dev_reset,
    input wire logic wdt_timeout,
    input wire logic master_clear_reset_pin,
    input wire logic int0_pin,
    input wire logic rtc_alarm,
    input wire logic wdt_en,
    input wire logic fail_safe_clock_monitor_en,
    input wire logic regulator_en,
    input wire logic deep_sleep_brownout_reset_cfg,
    input wire logic ds_wdt_timeout,
    input wire logic ds_bor_trip,
    input wire logic [15:0] gpr0_wdata,
    input wire logic [15:0] gpr1_wdata,
    input wire logic gpr_wr,
    output logic rtc_clk_en,
    output logic [1:0] mode_state,
    output logic ds_wdt_run,
    output logic ds_bor_run
);

    // ------------------------------------------------------------
    // States.
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_IDLE = 4'h2,
        ST_SLEEP = 4'h4,
        ST_DEEP = 4'h8
    } pstate_t;

    pstate_t state_r, state_nxt;
    logic en_r, en_nxt;
    logic [1:0] arm_cnt_r, arm_cnt_nxt;
    logic [psm_pkg::WK_WIDTH-1:0] wake_r, wake_nxt;
    logic pend_r, pend_nxt;
    logic vec_r, vec_nxt;
    logic wdtclr_r, wdtclr_nxt;
    logic [15:0] gpr0_r, gpr1_r;
    logic [2:0] master_clear_reset_s, int0_s, rtc_s;
    logic int0_rise, rtc_rise, master_clear_reset_fall;
    logic ds_entry, ds_exit, idle_wake, sleep_wake;

    // Two-flop synchronisers plus one history stage for the pin events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_clear_reset_s <= 3'h7;
            int0_s <= 3'h0;
            rtc_s <= 3'h0;
        end else begin
            master_clear_reset_s <= {master_clear_reset_s[1:0], master_clear_reset_pin};
            int0_s <= {int0_s[1:0], int0_pin};
            rtc_s <= {rtc_s[1:0], rtc_alarm};
        end
    end

    // Edge detectors read only the second and third stages.
    assign int0_rise = int0_s[1] & ~int0_s[2];
    assign rtc_rise = rtc_s[1] & ~rtc_s[2];
    assign master_clear_reset_fall = ~master_clear_reset_s[1] & master_clear_reset_s[2];

    // Deep sleep is honoured only with the regulator on and enable armed.
    assign ds_entry = link.psave_req && link.psave_mode == psm_pkg::PSAVE_SLEEP
        && en_r && regulator_en;
    // Any of the deep-sleep wake events ends deep sleep; the brown-out trip does so only with deep_sleep_brownout_reset_cfg set.
    assign ds_exit = dev_reset || master_clear_reset_fall || rtc_rise || int0_rise
        || ds_wdt_timeout || (ds_bor_trip && deep_sleep_brownout_reset_cfg);
    assign idle_wake = irq_any || pend_r || dev_reset || wdt_timeout;
    assign sleep_wake = irq_any || pend_r || dev_reset;

    // Next-state logic for mode, enable bit, arm window and wake flags.
    always_comb begin
        state_nxt = state_r;
        en_nxt = en_r;
        arm_cnt_nxt = arm_cnt_r;
        wake_nxt = wake_r;
        pend_nxt = pend_r;
        vec_nxt = 1'b0;
        wdtclr_nxt = 1'b0;
        if (link.wake_clr || link.release_clr) begin
            wake_nxt = '0;
        end
        if (en_r && state_r == ST_RUN && !link.psave_req) begin
            if (arm_cnt_r == 2'(psm_pkg::ARM_WINDOW_CYC - 1)) begin
                en_nxt = 1'b0;
            end else begin
                arm_cnt_nxt = arm_cnt_r + 2'h1;
            end
        end
        if (link.dsctl_wr) begin
            en_nxt = link.dsctl_wdata[psm_pkg::DSCTL_EN_BIT];
            arm_cnt_nxt = 2'h0;
            if (link.dsctl_wdata[psm_pkg::DSCTL_EN_BIT]) begin
                wake_nxt = '0;
            end
        end
        case (state_r)
            ST_RUN: begin
                if (link.psave_req) begin
                    pend_nxt = irq_any;
                    if (ds_entry) begin
                        state_nxt = ST_DEEP;
                        pend_nxt = 1'b0;
                    end else if (link.psave_mode == psm_pkg::PSAVE_IDLE) begin
                        state_nxt = ST_IDLE;
                        wdtclr_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_SLEEP;
                        wdtclr_nxt = 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                if (idle_wake) begin
                    state_nxt = ST_RUN;
                    vec_nxt = irq_any || pend_r;
                    pend_nxt = 1'b0;
                end
            end
            ST_SLEEP: begin
                if (sleep_wake) begin
                    state_nxt = ST_RUN;
                    vec_nxt = irq_any || pend_r;
                    pend_nxt = 1'b0;
                end
            end
            ST_DEEP: begin
                if (ds_exit) begin
                    state_nxt = ST_RUN;
                    en_nxt = 1'b0;
                    wake_nxt[psm_pkg::WK_POR] = wake_r[psm_pkg::WK_POR] | dev_reset;
                    wake_nxt[psm_pkg::WK_MASTER_CLEAR_RESET] = wake_r[psm_pkg::WK_MASTER_CLEAR_RESET] | master_clear_reset_fall;
                    wake_nxt[psm_pkg::WK_RTC] = wake_r[psm_pkg::WK_RTC] | rtc_rise;
                    wake_nxt[psm_pkg::WK_INT0] = wake_r[psm_pkg::WK_INT0] | int0_rise;
                    wake_nxt[psm_pkg::WK_DEEP_SLEEP_WATCHDOG] = wake_r[psm_pkg::WK_DEEP_SLEEP_WATCHDOG] | ds_wdt_timeout;
                    wake_nxt[psm_pkg::WK_DEEP_SLEEP_BROWNOUT_RESET] = wake_r[psm_pkg::WK_DEEP_SLEEP_BROWNOUT_RESET]
                        | (ds_bor_trip & deep_sleep_brownout_reset_cfg);
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RUN;
            en_r <= 1'b0;
            arm_cnt_r <= 2'h0;
            wake_r <= '0;
            pend_r <= 1'b0;
            vec_r <= 1'b0;
            wdtclr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            en_r <= en_nxt;
            arm_cnt_r <= arm_cnt_nxt;
            wake_r <= wake_nxt;
            pend_r <= pend_nxt;
            vec_r <= vec_nxt;
            wdtclr_r <= wdtclr_nxt;
        end
    end

    // Deep-sleep general-purpose registers survive deep sleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpr0_r <= 16'h0000;
            gpr1_r <= 16'h0000;
        end else if (gpr_wr) begin
            gpr0_r <= gpr0_wdata;
            gpr1_r <= gpr1_wdata;
        end
    end

    // Outputs toward the core and clock tree.
    assign link.core_run = state_r == ST_RUN;
    assign link.sysclk_on = state_r != ST_DEEP && state_r != ST_SLEEP;
    assign link.low_power_rc_osc_on = state_r == ST_RUN || ((wdt_en || fail_safe_clock_monitor_en)
        && state_r != ST_DEEP) || state_r == ST_DEEP;
    assign link.regulator_on = state_r != ST_DEEP;
    assign link.dsctl_rdata = {en_r, 15'h0000};
    assign link.wake_src = wake_r;
    assign link.wake_vector = vec_r;
    assign link.pending_irq = pend_r;
    assign link.wdt_clr = wdtclr_r;
    assign link.ds_gpr0 = gpr0_r;
    assign link.ds_gpr1 = gpr1_r;
    assign rtc_clk_en = 1'b1;
    assign ds_wdt_run = state_r == ST_DEEP;
    assign ds_bor_run = state_r == ST_DEEP && deep_sleep_brownout_reset_cfg;
    assign mode_state = state_r == ST_IDLE ? 2'h1 : state_r == ST_SLEEP ? 2'h2 :
        state_r == ST_DEEP ? 2'h3 : 2'h0;

endmodule

/* File: hdl/power_save_core_ctrl.sv */
`timescale 1ns/1ns
module power_save_core_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    psm_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    // ------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------
    logic [5:0] ctrl_r;
    logic [psm_pkg::EV_WIDTH-1:0] stat_r, stat_nxt, mask_r, ev;
    logic [1:0] cmd_r, cmd_nxt;
    logic [1:0] step_r, step_nxt;
    logic [1:0] gap_r, gap_nxt;
    logic was_run_r, was_en_r;
    logic wr, rd;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable;

    // Events seen from the device side.
    assign ev[psm_pkg::EV_IDLE_WAKE] = link.core_run && !was_run_r && link.wake_vector;
    assign ev[psm_pkg::EV_SLEEP_WAKE] = link.core_run && !was_run_r;
    assign ev[psm_pkg::EV_DS_WAKE] = |link.wake_src && link.core_run && !was_run_r;
    assign ev[psm_pkg::EV_ARM_LAPSE] = was_en_r && !link.dsctl_rdata[psm_pkg::DSCTL_EN_BIT]
        && link.core_run;

    // Command sequencer: idle and sleep issue at once; deep arms enable, then issues sleep the next cycle.
    always_comb begin
        cmd_nxt = cmd_r;
        step_nxt = step_r;
        gap_nxt = gap_r == 2'h0 ? 2'h0 : gap_r - 2'h1;
        stat_nxt = (stat_r & ~((wr && paddr == psm_pkg::REG_IRQ_STAT) ? pwdata[3:0] : 4'h0))
            | ev;
        link.psave_req = 1'b0;
        link.psave_mode = psm_pkg::PSAVE_SLEEP;
        link.dsctl_wr = 1'b0;
        link.dsctl_wdata = psm_pkg::DSCTL_RESET;
        link.release_clr = 1'b0;
        link.wake_clr = 1'b0;
        if (wr && paddr == psm_pkg::REG_WAKE) begin
            link.wake_clr = 1'b1;
            link.release_clr = 1'b1;
            gap_nxt = 2'(psm_pkg::REARM_GAP_CYC);
        end
        case (cmd_r)
            psm_pkg::CMD_IDLE: begin
                link.psave_req = link.core_run;
                link.psave_mode = psm_pkg::PSAVE_IDLE;
                cmd_nxt = psm_pkg::CMD_NONE;
            end
            psm_pkg::CMD_SLEEP: begin
                link.psave_req = link.core_run;
                cmd_nxt = psm_pkg::CMD_NONE;
            end
            psm_pkg::CMD_DEEP: begin
                if (step_r == 2'h0 && gap_r == 2'h0) begin
                    link.dsctl_wr = 1'b1;
                    link.dsctl_wdata[psm_pkg::DSCTL_EN_BIT] = 1'b1;
                    step_nxt = 2'h1;
                end else if (step_r == 2'h1) begin
                    link.psave_req = 1'b1;
                    step_nxt = 2'h0;
                    cmd_nxt = psm_pkg::CMD_NONE;
                end
            end
            default: begin
                cmd_nxt = psm_pkg::CMD_NONE;
            end
        endcase
        if (wr && paddr == psm_pkg::REG_CTRL) begin
            cmd_nxt = pwdata[9:8];
        end
    end

    // Register updates.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 6'h00;
            stat_r <= 4'h0;
            mask_r <= 4'h0;
            cmd_r <= psm_pkg::CMD_NONE;
            step_r <= 2'h0;
            gap_r <= 2'h0;
            was_run_r <= 1'b1;
            was_en_r <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            cmd_r <= cmd_nxt;
            step_r <= step_nxt;
            gap_r <= gap_nxt;
            stat_r <= stat_nxt;
            was_run_r <= link.core_run;
            was_en_r <= link.dsctl_rdata[psm_pkg::DSCTL_EN_BIT];
            if (wr && paddr == psm_pkg::REG_CTRL) begin
                ctrl_r <= pwdata[5:0];
            end
            if (wr && paddr == psm_pkg::REG_IRQ_MASK) begin
                mask_r <= pwdata[3:0];
            end
            if (rd) begin
                case (paddr)
                    psm_pkg::REG_CTRL: prdata <= {26'h0000000, ctrl_r};
                    psm_pkg::REG_STATUS: prdata <= {link.dsctl_rdata, 12'h000,
                        link.core_run, link.pending_irq, link.low_power_rc_osc_on, link.regulator_on};
                    psm_pkg::REG_IRQ_STAT: prdata <= {28'h0000000, stat_r};
                    psm_pkg::REG_IRQ_MASK: prdata <= {28'h0000000, mask_r};
                    psm_pkg::REG_WAKE: prdata <= {26'h0000000, link.wake_src};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // A set mask bit hides its status bit from the interrupt line.
    assign irq = |(stat_r & ~mask_r);

endmodule

/* File: tb/power_save_mode_control_assertions.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Checker on the signals between the core and the controller.
// ------------------------------------------------------------
module power_save_mode_control_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psave_req,
    input wire logic [1:0] psave_mode,
    input wire logic dsctl_wr,
    input wire logic [15:0] dsctl_wdata,
    input wire logic [15:0] dsctl_rdata,
    input wire logic [5:0] wake_src,
    input wire logic core_run,
    input wire logic wake_vector,
    input wire logic pending_irq,
    input wire logic wdt_clr,
    input wire logic sysclk_on,
    input wire logic regulator_on
);
    logic idle_go;
    logic idle_r;
    logic idle_nxt;

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    // An accepted idle request sets the flag; a running core clears it.
    assign idle_go = psave_req && (psave_mode == psm_pkg::PSAVE_IDLE) && core_run;
    always_comb begin
        idle_nxt = idle_r;
        if (idle_go) begin
            idle_nxt = 1'b1;
        end else if (core_run) begin
            idle_nxt = 1'b0;
        end
    end

    // Registers the idle flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_r <= 1'b0;
        end else begin
            idle_r <= idle_nxt;
        end
    end

    // ------------------------------------------------------------
    // Properties.
    // ------------------------------------------------------------
    a_idle_halts_core: assert property (idle_go |=> !core_run)
        else $error("core still running after idle request");
    a_idle_clears_wdt: assert property (idle_go |=> wdt_clr)
        else $error("watchdog not cleared on idle entry");
    a_idle_keeps_sysclk: assert property (idle_r |-> sysclk_on)
        else $error("system clock stopped in idle");
    a_arm_clears_wake: assert property (dsctl_wr && dsctl_wdata[psm_pkg::DSCTL_EN_BIT]
        |=> wake_src == 6'h00)
        else $error("wake sources not cleared when enable set");
    a_exit_drops_enable: assert property ($rose(regulator_on)
        |-> ##[0:2] !dsctl_rdata[psm_pkg::DSCTL_EN_BIT])
        else $error("deep sleep enable kept after exit");
    a_vector_one_pulse: assert property (wake_vector |=> !wake_vector)
        else $error("wake vector longer than one cycle");
    a_pending_wakes_now: assert property (pending_irq && !core_run && regulator_on
        |-> ##[1:4] core_run)
        else $error("pending interrupt did not wake the core");
    a_regoff_core_held: assert property (!regulator_on |-> !core_run)
        else $error("core running with regulator off");

    // Main scenarios reached.
    c_idle_entry: cover property (idle_go);
    c_deep_entry: cover property ($fell(regulator_on));
    c_pending_wake: cover property (pending_irq && !core_run);
endmodule

/* File: tb/power_save_mode_control_bench.sv */
`timescale 1ns/1ns
module power_save_mode_control_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    logic irq_any, dev_reset, wdt_timeout, master_clear_reset_pin, int0_pin, rtc_alarm, gpr_wr;
    logic wdt_en, fail_safe_clock_monitor_en, regulator_en, deep_sleep_brownout_reset_cfg, ds_wdt_timeout, ds_bor_trip;
    logic rtc_clk_en, ds_wdt_run, ds_bor_run;
    logic [1:0] mode_state;
    logic [15:0] gpr0_wdata, gpr1_wdata;
    int bad_count;
    int comparisons;
    int wk [6];

    psm_if link();

    power_save_mode_control power_save_mode_control_i (
        .pclk(pclk), .presetn(presetn), .link(link), .irq_any(irq_any),
        .dev_reset(dev_reset), .wdt_timeout(wdt_timeout), .master_clear_reset_pin(master_clear_reset_pin),
        .int0_pin(int0_pin), .rtc_alarm(rtc_alarm), .wdt_en(wdt_en), .fail_safe_clock_monitor_en(fail_safe_clock_monitor_en),
        .regulator_en(regulator_en), .deep_sleep_brownout_reset_cfg(deep_sleep_brownout_reset_cfg), .ds_wdt_timeout(ds_wdt_timeout),
        .ds_bor_trip(ds_bor_trip), .gpr0_wdata(gpr0_wdata), .gpr1_wdata(gpr1_wdata),
        .gpr_wr(gpr_wr), .rtc_clk_en(rtc_clk_en), .mode_state(mode_state),
        .ds_wdt_run(ds_wdt_run), .ds_bor_run(ds_bor_run));

    power_save_core_ctrl power_save_core_ctrl_i (
        .pclk(pclk), .presetn(presetn), .link(link), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    power_save_mode_control_assertions checker_i (
        .pclk(pclk), .presetn(presetn), .psave_req(link.psave_req),
        .psave_mode(link.psave_mode), .dsctl_wr(link.dsctl_wr),
        .dsctl_wdata(link.dsctl_wdata), .dsctl_rdata(link.dsctl_rdata),
        .wake_src(link.wake_src), .core_run(link.core_run), .wake_vector(link.wake_vector),
        .pending_irq(link.pending_irq), .wdt_clr(link.wdt_clr),
        .sysclk_on(link.sysclk_on), .regulator_on(link.regulator_on));

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    // Compares a value and counts the result.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, then one idle edge so strobes never toggle twice in a step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Waits a bounded time for the core run level.
    task automatic wait_run(input logic want);
        int n;
        n = 0;
        while (link.core_run !== want && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("core_run", 32'(link.core_run), 32'(want));
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Free-running 25 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        results();
    end

    // ------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------
    initial begin
        wk = '{psm_pkg::WK_MASTER_CLEAR_RESET, psm_pkg::WK_INT0, psm_pkg::WK_RTC, psm_pkg::WK_DEEP_SLEEP_WATCHDOG,
            psm_pkg::WK_DEEP_SLEEP_BROWNOUT_RESET, psm_pkg::WK_POR};
        bad_count = 0;
        comparisons = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        {irq_any, dev_reset, wdt_timeout, int0_pin, rtc_alarm, gpr_wr} = 6'h00;
        {wdt_en, fail_safe_clock_monitor_en, regulator_en, deep_sleep_brownout_reset_cfg, ds_wdt_timeout, ds_bor_trip} = 6'h00;
        master_clear_reset_pin = 1'b1;
        gpr0_wdata = 16'hA5C3;
        gpr1_wdata = 16'h3C5A;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("dsctl_rdata", 32'(link.dsctl_rdata), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", rd, 32'h0);
        apb(1'b0, psm_pkg::REG_STATUS, 32'h0);
        chk("status", rd, 32'h0000000B);
        chk("pslverr", 32'(pslverr), 32'h0);
        gpr_wr <= 1'b1;
        @(posedge pclk);
        gpr_wr <= 1'b0;
        // Idle entry and wake by interrupt, watchdog time-out and device reset.
        for (int k = 0; k < 3; k++) begin
            wdt_en <= (k == 0);
            fail_safe_clock_monitor_en <= (k == 1);
            cfg = (k < 2) ? (32'h1 << k) : 32'h0;
            apb(1'b1, psm_pkg::REG_CTRL, {22'h000000, psm_pkg::CMD_IDLE, 8'h00} | cfg);
            wait_run(1'b0);
            chk("mode_state", 32'(mode_state), 32'h1);
            chk("sysclk_on", 32'(link.sysclk_on), 32'h1);
            chk("low_power_rc_osc_on", 32'(link.low_power_rc_osc_on), (k < 2) ? 32'h1 : 32'h0);
            case (k)
                0: irq_any <= 1'b1;
                1: wdt_timeout <= 1'b1;
                default: dev_reset <= 1'b1;
            endcase
            @(posedge pclk);
            {irq_any, wdt_timeout, dev_reset} <= 3'h0;
            wait_run(1'b1);
            chk("mode_state", 32'(mode_state), 32'h0);
        end
        // Interrupt already raised while the idle, then the sleep, request is issued.
        irq_any <= 1'b1;
        for (int m = 1; m < 3; m++) begin
            apb(1'b1, psm_pkg::REG_CTRL,
                {22'h000000, ((m == 1) ? psm_pkg::CMD_IDLE : psm_pkg::CMD_SLEEP), 8'h00});
            wait_run(1'b0);
            chk("mode_state", 32'(mode_state), 32'(m));
            wait_run(1'b1);
        end
        irq_any <= 1'b0;
        // Deep sleep, left through each wake source in turn.
        regulator_en <= 1'b1;
        deep_sleep_brownout_reset_cfg <= 1'b1;
        for (int j = 0; j < 6; j++) begin
            apb(1'b1, psm_pkg::REG_CTRL, {22'h000000, psm_pkg::CMD_DEEP, 8'h3C});
            wait_run(1'b0);
            chk("mode_state", 32'(mode_state), 32'h3);
            chk("regulator_on", 32'(link.regulator_on), 32'h0);
            chk("rtc_clk_en", 32'(rtc_clk_en), 32'h1);
            chk("ds_monitors", 32'({ds_wdt_run, ds_bor_run}), 32'h3);
            case (j)
                0: master_clear_reset_pin <= 1'b0;
                1: int0_pin <= 1'b1;
                2: rtc_alarm <= 1'b1;
                3: ds_wdt_timeout <= 1'b1;
                4: ds_bor_trip <= 1'b1;
                default: dev_reset <= 1'b1;
            endcase
            @(posedge pclk);
            {master_clear_reset_pin, int0_pin, rtc_alarm, ds_wdt_timeout, ds_bor_trip, dev_reset} <= 6'h20;
            wait_run(1'b1);
            chk("wake_src", 32'(link.wake_src), 32'h1 << wk[j]);
            chk("enable", 32'(link.dsctl_rdata[psm_pkg::DSCTL_EN_BIT]), 32'h0);
            chk("gpr", {link.ds_gpr1, link.ds_gpr0}, 32'h3C5AA5C3);
            apb(1'b1, psm_pkg::REG_WAKE, 32'h0);
            repeat (3) @(posedge pclk);
            chk("wake_clear", 32'(link.wake_src), 32'h0);
        end
        // Without the regulator the request falls back to ordinary sleep.
        regulator_en <= 1'b0;
        apb(1'b1, psm_pkg::REG_CTRL, {22'h000000, psm_pkg::CMD_DEEP, 8'h38});
        wait_run(1'b0);
        chk("mode_state", 32'(mode_state), 32'h2);
        chk("regulator_on", 32'(link.regulator_on), 32'h1);
        irq_any <= 1'b1;
        @(posedge pclk);
        irq_any <= 1'b0;
        wait_run(1'b1);
        // The enable left armed by the fallback lapses after three cycles.
        chk("armed", 32'(link.dsctl_rdata[psm_pkg::DSCTL_EN_BIT]), 32'h1);
        repeat (3) @(posedge pclk);
        chk("arm_lapse", 32'(link.dsctl_rdata[psm_pkg::DSCTL_EN_BIT]), 32'h0);
        apb(1'b0, psm_pkg::REG_CTRL, 32'h0);
        chk("ctrl", rd, 32'h00000038);
        // Interrupt status, mask and write-one-to-clear.
        apb(1'b0, psm_pkg::REG_IRQ_STAT, 32'h0);
        chk("idle_wake_event", 32'(rd[psm_pkg::EV_IDLE_WAKE]), 32'h1);
        chk("arm_lapse_event", 32'(rd[psm_pkg::EV_ARM_LAPSE]), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, psm_pkg::REG_IRQ_MASK, 32'h0000000F);
        @(posedge pclk);
        chk("irq_masked", 32'(irq), 32'h0);
        apb(1'b1, psm_pkg::REG_IRQ_MASK, 32'h0);
        apb(1'b1, psm_pkg::REG_IRQ_STAT, 32'h0000000F);
        @(posedge pclk);
        chk("irq_cleared", 32'(irq), 32'h0);
        apb(1'b0, psm_pkg::REG_IRQ_STAT, 32'h0);
        chk("irq_stat", rd, 32'h0);
        results();
    end
endmodule
